// >>> rtl/dts_pkg.sv
// dts_pkg: constants and types of the two-channel temperature register block
// assumes one 125 MHz clock; all register codes are 8-bit command indices
package dts_pkg;

   // ***********************************************************************
   // command codes
   // ***********************************************************************
   localparam logic [7:0] CMD_LOCAL_TEMPERATURE  = 8'h00;
   localparam logic [7:0] CMD_REMOTE_TEMPERATURE = 8'h01;
   localparam logic [7:0] CMD_FAULT_FLAGS        = 8'h02;
   localparam logic [7:0] CMD_SETTINGS_READ      = 8'h03;
   localparam logic [7:0] CMD_LOCAL_LIMIT_READ   = 8'h05;
   localparam logic [7:0] CMD_REMOTE_LIMIT_READ  = 8'h07;
   localparam logic [7:0] CMD_SETTINGS_WRITE     = 8'h09;
   localparam logic [7:0] CMD_LOCAL_LIMIT_WRITE  = 8'h0b;
   localparam logic [7:0] CMD_REMOTE_LIMIT_WRITE = 8'h0d;
   localparam logic [7:0] CMD_ONE_CONVERSION     = 8'h0f;
   localparam logic [7:0] CMD_REMOTE_FRACTION    = 8'h10;
   localparam logic [7:0] CMD_LOCAL_FRACTION     = 8'h11;
   localparam logic [7:0] CMD_MAKER_IDENTIFIER   = 8'hfe;

   // ***********************************************************************
   // reset values and field positions
   // ***********************************************************************
   localparam logic [7:0] RST_COMMAND      = 8'h00;
   localparam logic [7:0] RST_SETTINGS     = 8'h10;
   localparam logic [7:0] RST_LOCAL_LIMIT  = 8'h46;
   localparam logic [7:0] RST_REMOTE_LIMIT = 8'h78;
   localparam logic [7:0] RST_TEMPERATURE  = 8'h00;
   localparam logic [7:0] FAULT_READING    = 8'hff;
   localparam logic [7:0] UNMAPPED_READ    = 8'hff;
   localparam logic [7:0] SETTINGS_MASK    = 8'hf0;
   localparam int         CFG_ALERT_DISABLE = 7;
   localparam int         CFG_STANDBY       = 6;
   localparam int         CFG_REMOTE_ONLY   = 5;
   localparam int         CFG_FAULT_QUEUE   = 4;
   localparam int         STS_BUSY          = 7;
   localparam int         STS_LOCAL_OVER    = 6;
   localparam int         STS_REMOTE_OVER   = 4;
   localparam int         STS_OPEN          = 2;
   localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0c;
   localparam logic [3:0] BITS_PER_BYTE     = 4'h8;

   // ***********************************************************************
   // types
   // ***********************************************************************
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_AACK = 7'h04,
      ST_RXB  = 7'h08,
      ST_RACK = 7'h10,
      ST_TXB  = 7'h20,
      ST_TACK = 7'h40
   } dts_state_e;

   // one finished conversion of one channel, quarter degrees, two's compl.
   typedef struct packed {
      logic              done;
      logic              fault;
      logic signed [11:0] temp;
   } dts_result_s;

endpackage

// >>> rtl/dts_core.sv
// dts_core: command index, temperature/limit registers, status, alert latch
// and the two-wire slave of a two-channel temperature sensor.
// assumes the conversion engine runs on ref_clk and pulses done per channel;
// scl and sda arrive asynchronously from the pins.
module dts_core
   import dts_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h48,
   // arbitrary identifier value
   parameter logic [7:0] MAKER_ID = 8'h5a
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // two-wire pins
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_oe_n,
   output logic             alert_oe_n,
   // conversion engine
   input  wire dts_result_s local_res,
   input  wire dts_result_s remote_res,
   input  wire logic        conv_busy,
   output logic             conv_standby,
   output logic             conv_remote_only,
   output logic             conv_single_start
);

   // ***********************************************************************
   // state
   // ***********************************************************************
   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      dts_state_e st;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic       rw;
      logic       ara;
      logic       got_cmd;
      logic       host_ack;
      logic       sda_oe_n;
      logic [7:0] cmd;
      logic [7:0] cfg;
      logic [7:0] lim_loc;
      logic [7:0] lim_rem;
      logic [7:0] t_loc;
      logic [7:0] t_rem;
      logic [7:0] x_loc;
      logic [7:0] x_rem;
      logic       ov_loc;
      logic       ov_rem;
      logic       open;
      logic       open_now;
      logic       prev_loc;
      logic       prev_rem;
      logic       alert;
      logic       alert_oe_n;
      logic       single_run;
      logic       single_start;
   } dts_core_s;

   dts_core_s q;
   dts_core_s n;

   // ***********************************************************************
   // helpers
   // ***********************************************************************
   // clamp quarter-degree reading into main byte and two fraction bits
   function automatic logic [9:0] clamp_temp(input logic signed [11:0] raw);
      logic [9:0] r;
      r = 10'h000;
      if (raw[11]) begin
         r = 10'h000;
      end else if (raw[10]) begin
         r = 10'h3ff;
      end else begin
         r = raw[9:0];
      end
      return r;
   endfunction

   function automatic logic [7:0] read_mux(input dts_core_s s,
                                           input logic busy);
      logic [7:0] r;
      r = UNMAPPED_READ;
      case (s.cmd)
         CMD_LOCAL_TEMPERATURE:  r = s.t_loc;
         CMD_REMOTE_TEMPERATURE: r = s.t_rem;
         CMD_FAULT_FLAGS: begin
            r = 8'h00;
            r[STS_BUSY]        = busy;
            r[STS_LOCAL_OVER]  = s.ov_loc;
            r[STS_REMOTE_OVER] = s.ov_rem;
            r[STS_OPEN]        = s.open;
         end
         CMD_SETTINGS_READ:      r = s.cfg;
         CMD_LOCAL_LIMIT_READ:   r = s.lim_loc;
         CMD_REMOTE_LIMIT_READ:  r = s.lim_rem;
         CMD_REMOTE_FRACTION:    r = s.x_rem;
         CMD_LOCAL_FRACTION:     r = s.x_loc;
         CMD_MAKER_IDENTIFIER:   r = MAKER_ID;
         default:                r = UNMAPPED_READ;
      endcase
      return r;
   endfunction

   // ***********************************************************************
   // next state
   // ***********************************************************************
   logic       scl_rise;
   logic       scl_fall;
   logic       bus_start;
   logic       bus_stop;
   logic       sda_bit;
   logic [9:0] v_loc;
   logic [9:0] v_rem;
   logic       f_loc;
   logic       f_rem;
   logic       over_now;
   logic       stat_read;
   logic       ara_done;

   always_comb begin
      n = q;
      // first stage feeds only the second; edges use stages two and three
      n.scl_s = {q.scl_s[1:0], scl_in};
      n.sda_s = {q.sda_s[1:0], sda_in};
      scl_rise  = q.scl_s[1] & ~q.scl_s[2];
      scl_fall  = ~q.scl_s[1] & q.scl_s[2];
      bus_start = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[1] & q.sda_s[2];
      bus_stop  = q.scl_s[1] & q.scl_s[2] & q.sda_s[1] & ~q.sda_s[2];
      sda_bit   = q.sda_s[1];
      stat_read = 1'b0;
      ara_done  = 1'b0;
      n.single_start = 1'b0;

      // *********************************************************************
      // two-wire slave
      // *********************************************************************
      // a repeated start simply restarts address reception; the stored
      // index survives it, which is what makes read byte work
      if (bus_start) begin
         n.st       = ST_ADDR;
         n.bitc     = 4'h0;
         n.sda_oe_n = 1'b1;
      end else if (bus_stop) begin
         n.st       = ST_IDLE;
         n.sda_oe_n = 1'b1;
      end else begin
         case (q.st)
            ST_IDLE: n.sda_oe_n = 1'b1;
            ST_ADDR: begin
               if (scl_rise) begin
                  n.sh   = {q.sh[6:0], sda_bit};
                  n.bitc = q.bitc + 4'h1;
               end else if (scl_fall && q.bitc == BITS_PER_BYTE) begin
                  n.rw  = q.sh[0];
                  n.ara = (q.sh[7:1] == ALERT_RESPONSE_ADDR);
                  if (q.sh[7:1] == DEV_ADDR ||
                      (q.sh[7:1] == ALERT_RESPONSE_ADDR && q.sh[0] &&
                       q.alert)) begin
                     n.sda_oe_n = 1'b0;
                     n.st       = ST_AACK;
                  end else begin
                     n.st = ST_IDLE;
                  end
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  n.bitc    = 4'h0;
                  n.got_cmd = 1'b0;
                  if (q.rw) begin
                     // receive byte and read byte both answer from the index
                     if (q.ara) begin
                        n.sh = {DEV_ADDR, 1'b0};
                     end else begin
                        n.sh = read_mux(q, conv_busy);
                        stat_read = (q.cmd == CMD_FAULT_FLAGS);
                     end
                     n.sda_oe_n = n.sh[7];
                     n.st       = ST_TXB;
                  end else begin
                     n.sda_oe_n = 1'b1;
                     n.st       = ST_RXB;
                  end
               end
            end
            ST_RXB: begin
               if (scl_rise) begin
                  n.sh   = {q.sh[6:0], sda_bit};
                  n.bitc = q.bitc + 4'h1;
               end else if (scl_fall && q.bitc == BITS_PER_BYTE) begin
                  n.sda_oe_n = 1'b0;
                  n.st       = ST_RACK;
                  n.got_cmd  = 1'b1;
                  if (!q.got_cmd) begin
                     n.cmd = q.sh;
                  end else begin
                     // read-only codes and the identifier ignore writes
                     case (q.cmd)
                        CMD_SETTINGS_WRITE:
                           n.cfg = q.sh & SETTINGS_MASK;
                        CMD_LOCAL_LIMIT_WRITE:  n.lim_loc = q.sh;
                        CMD_REMOTE_LIMIT_WRITE: n.lim_rem = q.sh;
                        default: n.cmd = q.cmd;
                     endcase
                  end
                  // send byte form: command alone carries the trigger
                  if ((!q.got_cmd && q.sh == CMD_ONE_CONVERSION) ||
                      (q.got_cmd && q.cmd == CMD_ONE_CONVERSION)) begin
                     if (q.cfg[CFG_STANDBY] && !q.single_run &&
                         !conv_busy) begin
                        n.single_start = 1'b1;
                        n.single_run   = 1'b1;
                     end
                  end
               end
            end
            ST_RACK: begin
               if (scl_fall) begin
                  n.sda_oe_n = 1'b1;
                  n.bitc     = 4'h0;
                  n.st       = ST_RXB;
               end
            end
            ST_TXB: begin
               if (scl_rise) begin
                  n.bitc = q.bitc + 4'h1;
                  // lost arbitration on the alert response: back off
                  if (q.sda_oe_n && !sda_bit && q.ara) begin
                     n.st = ST_IDLE;
                  end
               end else if (scl_fall) begin
                  if (q.bitc == BITS_PER_BYTE) begin
                     n.sda_oe_n = 1'b1;
                     n.st       = ST_TACK;
                  end else begin
                     n.sh       = {q.sh[6:0], 1'b0};
                     n.sda_oe_n = q.sh[6];
                  end
               end
            end
            ST_TACK: begin
               if (scl_rise) begin
                  n.host_ack = ~sda_bit;
                  ara_done   = q.ara;
               end else if (scl_fall) begin
                  n.bitc = 4'h0;
                  if (q.host_ack && !q.ara) begin
                     n.sh       = read_mux(q, conv_busy);
                     n.sda_oe_n = n.sh[7];
                     n.st       = ST_TXB;
                  end else begin
                     n.st = ST_IDLE;
                  end
               end
            end
            default: begin
               n.st       = ST_IDLE;
               n.sda_oe_n = 1'b1;
            end
         endcase
      end

      // *********************************************************************
      // status clears, then conversion results (a set beats a clear)
      // *********************************************************************
      over_now = (q.t_loc >= q.lim_loc) ||
                 (!q.open_now && q.t_rem >= q.lim_rem);
      if (stat_read) begin
         n.ov_loc = 1'b0;
         n.ov_rem = 1'b0;
         n.open   = q.open & q.open_now;
         n.alert  = q.alert & over_now;
      end
      n.alert = n.alert & ~ara_done;

      v_loc = clamp_temp(local_res.temp);
      v_rem = clamp_temp(remote_res.temp);
      f_loc = 1'b0;
      f_rem = 1'b0;
      if (local_res.done) begin
         n.t_loc = v_loc[9:2];
         n.x_loc = {v_loc[1:0], 6'h00};
         f_loc   = (v_loc[9:2] >= q.lim_loc);
         n.prev_loc = f_loc;
         n.ov_loc   = n.ov_loc | f_loc;
      end
      if (remote_res.done) begin
         n.open_now   = remote_res.fault;
         n.single_run = 1'b0;
         if (remote_res.fault) begin
            // flagged only once a conversion has ended, never at reset
            n.t_rem = FAULT_READING;
            n.x_rem = 8'h00;
            n.open  = 1'b1;
         end else begin
            n.t_rem = v_rem[9:2];
            n.x_rem = {v_rem[1:0], 6'h00};
            f_rem   = (v_rem[9:2] >= q.lim_rem);
         end
         // a faulted diode reads all ones but is kept out of the compare
         n.prev_rem = f_rem;
         n.ov_rem   = n.ov_rem | f_rem;
      end
      // fault queue asks for the previous result of the same channel too
      if (!q.cfg[CFG_ALERT_DISABLE] &&
          ((f_loc && (!q.cfg[CFG_FAULT_QUEUE] || q.prev_loc)) ||
           (f_rem && (!q.cfg[CFG_FAULT_QUEUE] || q.prev_rem)))) begin
         n.alert = 1'b1;
      end
      n.alert_oe_n = ~n.alert;
   end

   // ***********************************************************************
   // registers
   // ***********************************************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q              <= '0;
         q.scl_s        <= 3'h7;
         q.sda_s        <= 3'h7;
         q.st           <= ST_IDLE;
         q.sda_oe_n     <= 1'b1;
         q.alert_oe_n   <= 1'b1;
         q.cmd          <= RST_COMMAND;
         q.cfg          <= RST_SETTINGS;
         q.lim_loc      <= RST_LOCAL_LIMIT;
         q.lim_rem      <= RST_REMOTE_LIMIT;
         q.t_loc        <= RST_TEMPERATURE;
         q.t_rem        <= RST_TEMPERATURE;
      end else begin
         q <= n;
      end
   end

   assign sda_oe_n          = q.sda_oe_n;
   assign alert_oe_n        = q.alert_oe_n;
   assign conv_standby      = q.cfg[CFG_STANDBY];
   assign conv_remote_only  = q.cfg[CFG_REMOTE_ONLY];
   assign conv_single_start = q.single_start;

endmodule

// >>> test/dts_checker.sv
// dts_checker: port timing checks of dts_core
// assumes a bind to dts_core; one clock, async active-low reset
module dts_checker
   import dts_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rstn,
   // bus pins
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_oe_n,
   input wire logic        alert_oe_n,
   // conversion engine
   input wire dts_result_s local_res,
   input wire dts_result_s remote_res,
   input wire logic        conv_busy,
   input wire logic        conv_standby,
   input wire logic        conv_remote_only,
   input wire logic        conv_single_start
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // bus activity counter
   // ****
   // alert clears only ever follow bus traffic
   logic [4:0] quiet_q, quiet_d;
   logic       scl_q, scl_d;

   always_comb begin
      scl_d   = scl_in;
      quiet_d = quiet_q;
      if (scl_in != scl_q)
         quiet_d = 5'h00;
      else if (quiet_q != 5'h1f)
         quiet_d = quiet_q + 5'h01;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         scl_q   <= 1'b1;
         quiet_q <= 5'h1f;
      end else begin
         scl_q   <= scl_d;
         quiet_q <= quiet_d;
      end
   end

   // ****
   // assertions
   // ****
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_reset_idle:
      assert property ($rose(rstn) |-> alert_oe_n && sda_oe_n &&
                       !conv_standby && !conv_remote_only)
      else $error("outputs active after reset");
   a_shot_pulse:
      assert property (conv_single_start |=> !conv_single_start)
      else $error("single shot start too long");
   a_shot_standby:
      assert property (conv_single_start |->
                       conv_standby && !$past(conv_busy))
      else $error("single shot outside standby");
   a_alert_cause:
      assert property ($fell(alert_oe_n) |->
                       $past(local_res.done || remote_res.done))
      else $error("alert without a result");
   a_fault_quiet:
      assert property ($fell(alert_oe_n) |->
                       !$past(remote_res.fault && !local_res.done))
      else $error("alert from diode fault");
   a_alert_clear:
      assert property ($rose(alert_oe_n) |-> quiet_q < 5'h10)
      else $error("alert released without bus");
   a_sda_steady:
      assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
      else $error("sda moved while scl high");
   a_ack_holds:
      assert property ($fell(sda_oe_n) |=> !sda_oe_n [*5])
      else $error("sda low bit too short");
endmodule

// >>> test/dts_host_model.sv
// dts_host_model: two-wire bus master for the sensor pins
// assumes a pull-up on sda (driving 1 releases it); scl is push-pull
module dts_host_model
   import dts_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h48
) (
   // clock
   input wire logic  ref_clk,
   // bus pins
   output logic      scl,
   output logic      sda_drv,
   input  wire logic sda_wire
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****
   // bit timing: 80 ns, six cycles low and four high
   // ****
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // long low phase leaves the slave room to turn sda round
   task automatic put_bit(input logic b, output logic r);
      tick(3);
      sda_drv <= b;
      tick(3);
      scl <= 1'b1;
      tick(2);
      r = sda_wire;
      tick(2);
      scl <= 1'b0;
   endtask

   task automatic put_byte(input logic [7:0] b, input logic ack_in,
                           output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--)
         put_bit(b[i], r[i]);
      put_bit(ack_in, ack);
   endtask

   // rise 0: start or repeated start, rise 1: stop
   task automatic frame_edge(input logic rise);
      tick(3);
      sda_drv <= ~rise;
      tick(3);
      scl <= 1'b1;
      tick(3);
      sda_drv <= rise;
      tick(3);
      scl <= rise;
   endtask

   // kind 0 write, 1 read, 2 send, 3 receive, 4 alert response
   task automatic xfer(input int kind, input logic [7:0] cmd,
                       input logic [7:0] dat, output logic [7:0] rd,
                       output logic nak);
      logic [7:0] x;
      logic       a;
      logic [6:0] adr;
      adr = (kind == 4) ? ALERT_RESPONSE_ADDR : DEV_ADDR;
      nak = 1'b0;
      rd  = 8'h00;
      frame_edge(1'b0);
      if (kind < 3) begin
         put_byte({adr, 1'b0}, 1'b1, x, a);
         nak |= a;
         put_byte(cmd, 1'b1, x, a);
         nak |= a;
      end
      if (kind == 0) begin
         put_byte(dat, 1'b1, x, a);
         nak |= a;
      end
      if (kind == 1)
         frame_edge(1'b0);
      if (kind == 1 || kind > 2) begin
         put_byte({adr, 1'b1}, 1'b1, x, a);
         nak |= a;
         put_byte(8'hff, 1'b1, rd, a);
      end
      frame_edge(1'b1);
   endtask
endmodule

// >>> test/dts_core_bench.sv
// dts_core_bench: self-checking bench of the temperature register block
// assumes dts_core, dts_host_model and dts_checker compiled before it
module dts_core_bench
   import dts_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   // arbitrary identifier value
   localparam logic [7:0] MAKER_ID_EXP = 8'h5a;
   localparam logic [7:0] CODES [9] = '{8'h00, 8'h01, 8'h02, 8'h03,
      8'h05, 8'h07, 8'h10, 8'h11, 8'hfe};
   localparam logic [7:0] RESETS [9] = '{8'h00, 8'h00, 8'h00, 8'h10,
      8'h46, 8'h78, 8'h00, 8'h00, MAKER_ID_EXP};

   logic        ref_clk         = 1'b0;
   logic        rstn            = 1'b0;
   logic        conv_busy       = 1'b0;
   dts_result_s local_res       = '0;
   dts_result_s remote_res      = 14'h1000; // diode open from power-up
   logic        scl, sda_drv, sda_wire, sda_oe_n, alert_oe_n;
   logic        conv_standby, conv_remote_only, conv_single_start;
   logic [7:0]  rd;
   logic        nak;
   int          err_total       = 0;
   int          samples_checked = 0;
   int          shots           = 0;

   always #4 ref_clk = ~ref_clk;
   assign sda_wire = sda_drv & sda_oe_n;

   always @(negedge ref_clk) begin
      if (conv_single_start === 1'b1)
         shots++;
   end

   dts_core #(.MAKER_ID(MAKER_ID_EXP)) dut (
      .ref_clk(ref_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_wire),
      .sda_oe_n(sda_oe_n), .alert_oe_n(alert_oe_n),
      .local_res(local_res), .remote_res(remote_res),
      .conv_busy(conv_busy), .conv_standby(conv_standby),
      .conv_remote_only(conv_remote_only),
      .conv_single_start(conv_single_start));
   dts_host_model host (.ref_clk(ref_clk), .scl(scl), .sda_drv(sda_drv),
      .sda_wire(sda_wire));

   // ****
   // tasks
   // ****
   task automatic end_sim();
      if (err_total == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bus(input int kind, input logic [7:0] cmd,
                      input logic [7:0] dat);
      host.xfer(kind, cmd, dat, rd, nak);
      check({7'h00, nak}, 8'h00);
   endtask

   task automatic rd_reg(input logic [7:0] cmd, input logic [7:0] exp,
                         input logic [7:0] msk = 8'hff);
      bus(1, cmd, 8'h00);
      check(rd & msk, exp);
   endtask

   task automatic conv(input logic rem, input logic flt, input int q);
      @(posedge ref_clk);
      if (rem)
         remote_res <= '{1'b1, flt, q[11:0]};
      else
         local_res <= '{1'b1, 1'b0, q[11:0]};
      @(posedge ref_clk);
      local_res.done  <= 1'b0;
      remote_res.done <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic chk_alert(input logic exp);
      @(negedge ref_clk);
      check({7'h00, alert_oe_n}, {7'h00, exp});
   endtask

   // ****
   // sequence
   // ****
   initial begin
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      bus(3, 8'h00, 8'h00);
      check(rd, 8'h00);
      for (int i = 0; i < 9; i++)
         rd_reg(CODES[i], RESETS[i]);
      bus(0, CMD_LOCAL_LIMIT_WRITE, 8'h20);
      bus(0, CMD_LOCAL_LIMIT_READ, 8'h33);
      bus(0, CMD_REMOTE_LIMIT_WRITE, 8'h90);
      bus(0, CMD_MAKER_IDENTIFIER, 8'h00);
      rd_reg(CMD_LOCAL_LIMIT_READ, 8'h20);
      rd_reg(CMD_MAKER_IDENTIFIER, MAKER_ID_EXP);
      bus(2, CMD_REMOTE_LIMIT_READ, 8'h00);
      bus(3, 8'h00, 8'h00);
      check(rd, 8'h90);
      conv(1'b0, 1'b0, 103);
      conv(1'b1, 1'b0, 521);
      rd_reg(CMD_LOCAL_TEMPERATURE, 8'h19);
      rd_reg(CMD_LOCAL_FRACTION, 8'hc0, 8'hc0);
      rd_reg(CMD_REMOTE_TEMPERATURE, 8'h82);
      rd_reg(CMD_REMOTE_FRACTION, 8'h40, 8'hc0);
      conv(1'b0, 1'b0, -32);
      rd_reg(CMD_LOCAL_TEMPERATURE, 8'h00);
      bus(0, CMD_SETTINGS_WRITE, 8'h00);
      rd_reg(CMD_SETTINGS_READ, 8'h00);
      conv(1'b0, 1'b0, 128);
      chk_alert(1'b0);
      rd_reg(CMD_FAULT_FLAGS, 8'h40);
      chk_alert(1'b0);
      conv(1'b0, 1'b0, 40);
      chk_alert(1'b0);
      rd_reg(CMD_FAULT_FLAGS, 8'h00);
      chk_alert(1'b1);
      bus(0, CMD_SETTINGS_WRITE, 8'h80);
      conv(1'b0, 1'b0, 128);
      chk_alert(1'b1);
      conv(1'b0, 1'b0, 40);
      bus(0, CMD_SETTINGS_WRITE, 8'h10);
      conv(1'b0, 1'b0, 128);
      chk_alert(1'b1);
      conv(1'b0, 1'b0, 128);
      chk_alert(1'b0);
      bus(4, 8'h00, 8'h00);
      check({rd[7:1], 1'b0}, 8'h90);
      chk_alert(1'b1);
      // queue off, so a faulted reading that reached the compare would show
      bus(0, CMD_SETTINGS_WRITE, 8'h00);
      conv(1'b1, 1'b1, 0);
      rd_reg(CMD_REMOTE_TEMPERATURE, 8'hff);
      chk_alert(1'b1);
      rd_reg(CMD_FAULT_FLAGS, 8'h44);
      conv(1'b1, 1'b0, 100);
      rd_reg(CMD_FAULT_FLAGS, 8'h04);
      rd_reg(CMD_FAULT_FLAGS, 8'h00);
      conv(1'b1, 1'b0, 576);
      chk_alert(1'b0);
      rd_reg(CMD_FAULT_FLAGS, 8'h10);
      bus(2, CMD_ONE_CONVERSION, 8'h00);
      bus(0, CMD_SETTINGS_WRITE, 8'h7f);
      rd_reg(CMD_SETTINGS_READ, 8'h70);
      check({7'h00, conv_standby}, 8'h01);
      check({7'h00, conv_remote_only}, 8'h01);
      bus(2, CMD_ONE_CONVERSION, 8'h00);
      bus(2, CMD_ONE_CONVERSION, 8'h00);
      check(shots[7:0], 8'h01);
      conv(1'b1, 1'b0, 100);
      conv_busy <= 1'b1;
      rd_reg(CMD_FAULT_FLAGS, 8'h80);
      bus(2, CMD_ONE_CONVERSION, 8'h00);
      conv_busy <= 1'b0;
      bus(2, CMD_ONE_CONVERSION, 8'h00);
      check(shots[7:0], 8'h02);
      end_sim();
   end

   // hang guard, several times the expected run
   initial begin
      #600us;
      err_total++;
      end_sim();
   end
endmodule

bind dts_core dts_checker u_chk (
   .ref_clk(ref_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
   .sda_oe_n(sda_oe_n), .alert_oe_n(alert_oe_n), .local_res(local_res),
   .remote_res(remote_res), .conv_busy(conv_busy),
   .conv_standby(conv_standby), .conv_remote_only(conv_remote_only),
   .conv_single_start(conv_single_start));
